// ---- logic/eie_exec.sv ----
`timescale 1ns/1ps
`include "eie_defines.svh"
module eie_exec
  import eie_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic extSetEnable,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [`EIE_PC_W-1:0] pcNow,
  input wire logic [7:0] workingReg,
  input wire logic [7:0] pcHighLatch,
  input wire logic [7:0] pcUpperLatch,
  input wire logic [`EIE_PC_W-1:0] topOfStack,
  input wire logic [7:0] memRdData,
  input wire logic [2:0] ptrLoad,
  input wire logic [`EIE_ADDR_W-1:0] ptrLoadData,
  output logic instrReady,
  output logic instrDone,
  output logic [`EIE_ADDR_W-1:0] ptr0,
  output logic [`EIE_ADDR_W-1:0] ptr1,
  output logic [`EIE_ADDR_W-1:0] ptr2,
  output logic [`EIE_ADDR_W-1:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [7:0] memWrData,
  output logic pcLoad,
  output logic [`EIE_PC_W-1:0] pcValue,
  output logic stackPush,
  output logic [`EIE_PC_W-1:0] stackPushData,
  output logic stackPop
);

  eie_regs_t cur_r;
  eie_regs_t cur_nxt;

  function automatic logic inWindow(
    input logic [`EIE_ADDR_W-1:0] a,
    input logic [`EIE_ADDR_W-1:0] base
  );
    inWindow = (a >= base) && (a < base + `EIE_IND_SPAN);
  endfunction

  function automatic logic isIndirect(
    input logic [`EIE_ADDR_W-1:0] a
  );
    isIndirect = inWindow(a, `EIE_IND0_BASE) ||
                 inWindow(a, `EIE_IND1_BASE) ||
                 inWindow(a, `EIE_IND2_BASE);
  endfunction

  logic [7:0] opHigh;
  logic [1:0] sel;
  logic [`EIE_ADDR_W-1:0] lit6;
  logic [`EIE_ADDR_W-1:0] lit7;
  logic [`EIE_ADDR_W-1:0] spNow;
  logic [`EIE_ADDR_W-1:0] srcAddr;
  logic [`EIE_ADDR_W-1:0] dstAddr;
  logic [7:0] moveData;
  logic take;

  assign opHigh = instrWord[15:8];
  assign sel = instrWord[7:6];
  assign lit6 = {6'h00, instrWord[5:0]};
  assign lit7 = {5'h00, instrWord[6:0]};
  assign spNow = cur_r.ptr[`EIE_SP_IDX];
  // Offsets wrap inside the 4 KB data space
  assign srcAddr = spNow + lit7;
  assign take = instrValid && cur_r.ready && extSetEnable;

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.memRd = 1'b0;
    cur_nxt.memWr = 1'b0;
    cur_nxt.pcLoad = 1'b0;
    cur_nxt.pushReq = 1'b0;
    cur_nxt.popReq = 1'b0;
    cur_nxt.done = 1'b0;
    dstAddr = instrWord[`EIE_ADDR_W-1:0];
    moveData = cur_r.srcData;

    // Core writes to the pointers come first; an extended update in the
    // same cycle overrides them because it is the executing instruction.
    for (int i = 0; i < 3; i++) begin
      if (ptrLoad[i]) begin
        cur_nxt.ptr[i] = ptrLoadData;
      end
    end

    case (cur_r.st)
      EIE_IDLE: begin
        if (take) begin
          if (opHigh == `EIE_OP_ADD || opHigh == `EIE_OP_SUB) begin
            if (sel == `EIE_SEL_SP) begin
              // Only the stack pointer moves, whatever else is encoded
              if (opHigh == `EIE_OP_ADD) begin
                cur_nxt.ptr[`EIE_SP_IDX] = spNow + lit6;
              end else begin
                cur_nxt.ptr[`EIE_SP_IDX] = spNow - lit6;
              end
              cur_nxt.pcLoad = 1'b1;
              cur_nxt.pcValue = topOfStack;
              cur_nxt.popReq = 1'b1;
              cur_nxt.st = EIE_NOP;
              cur_nxt.ready = 1'b0;
            end else if (opHigh == `EIE_OP_ADD) begin
              cur_nxt.ptr[sel] = cur_r.ptr[sel] + lit6;
              cur_nxt.done = 1'b1;
            end else begin
              cur_nxt.ptr[sel] = cur_r.ptr[sel] - lit6;
              cur_nxt.done = 1'b1;
            end
          end else if (instrWord == `EIE_OP_CALL_VIA_WORKING_REGISTER) begin
            cur_nxt.pushReq = 1'b1;
            cur_nxt.pushData = pcNow + `EIE_PC_STEP;
            cur_nxt.pcLoad = 1'b1;
            // Upper latch carries only the bits the PC can hold
            cur_nxt.pcValue = {pcUpperLatch[`EIE_PC_W-17:0],
                               pcHighLatch, workingReg};
            // No path to working, status or bank select exists here
            cur_nxt.st = EIE_NOP;
            cur_nxt.ready = 1'b0;
          end else if (opHigh == `EIE_OP_PUSH) begin
            cur_nxt.memAddr = spNow;
            cur_nxt.memWrData = instrWord[7:0];
            cur_nxt.memWr = 1'b1;
            cur_nxt.ptr[`EIE_SP_IDX] = spNow - `EIE_SP_DEC;
            cur_nxt.done = 1'b1;
          end else if (opHigh == `EIE_OP_MOV) begin
            cur_nxt.indexedMove = instrWord[7];
            cur_nxt.memAddr = srcAddr;
            // Indirect source must not trigger its side effects
            cur_nxt.srcZero = isIndirect(srcAddr);
            cur_nxt.memRd = !isIndirect(srcAddr);
            cur_nxt.srcData = `EIE_ZERO_BYTE;
            cur_nxt.st = EIE_WORD2;
          end
        end
      end

      EIE_NOP: begin
        // Second cycle of return or call: target word is being fetched
        cur_nxt.st = EIE_IDLE;
        cur_nxt.ready = 1'b1;
        cur_nxt.done = 1'b1;
      end

      EIE_WORD2: begin
        if (cur_r.srcZero) begin
          moveData = `EIE_ZERO_BYTE;
        end else if (cur_r.memRd) begin
          moveData = memRdData;
        end
        cur_nxt.srcData = moveData;
        if (instrValid) begin
          if (cur_r.indexedMove) begin
            dstAddr = spNow + {5'h00, instrWord[6:0]};
          end else begin
            dstAddr = instrWord[`EIE_ADDR_W-1:0];
          end
          cur_nxt.st = EIE_IDLE;
          cur_nxt.done = 1'b1;
          // A malformed second word aborts the move without a write
          if (instrWord[15:12] == `EIE_W2_TAG &&
              !(cur_r.indexedMove && isIndirect(dstAddr))) begin
            cur_nxt.memAddr = dstAddr;
            cur_nxt.memWrData = moveData;
            cur_nxt.memWr = 1'b1;
          end
        end
      end

      default: begin
        cur_nxt.st = EIE_IDLE;
        cur_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_r <= '0;
      cur_r.st <= EIE_IDLE;
      cur_r.ready <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign instrReady = cur_r.ready;
  assign instrDone = cur_r.done;
  assign ptr0 = cur_r.ptr[0];
  assign ptr1 = cur_r.ptr[1];
  assign ptr2 = cur_r.ptr[2];
  assign memAddr = cur_r.memAddr;
  assign memRd = cur_r.memRd;
  assign memWr = cur_r.memWr;
  assign memWrData = cur_r.memWrData;
  assign pcLoad = cur_r.pcLoad;
  assign pcValue = cur_r.pcValue;
  assign stackPush = cur_r.pushReq;
  assign stackPushData = cur_r.pushData;
  assign stackPop = cur_r.popReq;

endmodule

// ---- logic/eie_defines.svh ----
`ifndef EIE_DEFINES_SVH
`define EIE_DEFINES_SVH

`define EIE_ADDR_W 12
`define EIE_PC_W 21
`define EIE_OP_ADD 8'hE8
`define EIE_OP_SUB 8'hE9
`define EIE_OP_PUSH 8'hEA
`define EIE_OP_MOV 8'hEB
`define EIE_OP_CALL_VIA_WORKING_REGISTER 16'h0014
`define EIE_W2_TAG 4'hF
`define EIE_SEL_SP 2'h3
`define EIE_SP_IDX 2
`define EIE_PC_STEP 21'h000002
`define EIE_ZERO_BYTE 8'h00
`define EIE_SP_DEC 12'h001
// Indirect register windows: five consecutive addresses per pointer
`define EIE_IND0_BASE 12'hFEB
`define EIE_IND1_BASE 12'hFE3
`define EIE_IND2_BASE 12'hFDB
`define EIE_IND_SPAN 12'h005
`endif

// ---- logic/eie_pkg.sv ----
`include "eie_defines.svh"
package eie_pkg;
  typedef enum logic [2:0] {
    EIE_IDLE = 3'b001,
    EIE_NOP = 3'b010,
    EIE_WORD2 = 3'b100
  } eie_state_e_t;

  typedef struct packed {
    eie_state_e_t st;
    logic [2:0][`EIE_ADDR_W-1:0] ptr;
    logic indexedMove;
    logic srcZero;
    logic [7:0] srcData;
    logic [`EIE_ADDR_W-1:0] memAddr;
    logic memRd;
    logic memWr;
    logic [7:0] memWrData;
    logic pcLoad;
    logic [`EIE_PC_W-1:0] pcValue;
    logic pushReq;
    logic [`EIE_PC_W-1:0] pushData;
    logic popReq;
    logic ready;
    logic done;
  } eie_regs_t;
endpackage

// ---- sim/eie_exec_checker.sv ----
`timescale 1ns/1ps
module eie_exec_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic extSetEnable,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic [11:0] ptr2,
  input wire logic [11:0] memAddr,
  input wire logic memWr,
  input wire logic [7:0] memWrData,
  input wire logic pcLoad,
  input wire logic [20:0] pcValue,
  input wire logic [20:0] topOfStack,
  input wire logic stackPush,
  input wire logic stackPop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Tracks a pending second move word so it is not mistaken for an opcode
  logic [1:0] mv_r;
  wire logic ft = instrValid && instrReady && extSetEnable && !mv_r[1];
  wire logic w2 = mv_r[1] && instrValid;
  wire logic [11:0] kk = {6'h00, instrWord[5:0]};
  wire logic [11:0] nsp = instrWord[8] ? ptr2 - kk : ptr2 + kk;
  wire logic arith = ft && instrWord[15:9] == 7'h74;
  always_ff @(posedge mclk)
    if (!rst_n)
      mv_r <= 2'h0;
    else if (mv_r[1])
      mv_r <= instrValid ? 2'h0 : mv_r;
    else if (ft && instrWord[15:8] == 8'hEB)
      mv_r <= {1'b1, instrWord[7]};
  sequence s_nop;
    pcLoad && !instrReady ##1 instrDone && instrReady;
  endsequence
  chk_ret_nop: assert property (stackPop |-> s_nop)
    else $error("return without no-op cycle");
  chk_call_nop: assert property (stackPush |-> s_nop)
    else $error("call without no-op cycle");
  chk_ext_off: assert property (instrValid && !extSetEnable && !mv_r[1]
    |=> !memWr && !pcLoad && !stackPush) else $error("ran while disabled");
  chk_push_lit: assert property (ft && instrWord[15:8] == 8'hEA
    |=> memWr && memAddr == $past(ptr2) && ptr2 == $past(ptr2) - 12'h001
    && memWrData == $past(instrWord[7:0])) else $error("push literal bad");
  chk_sp_ret: assert property (arith && instrWord[7:6] == 2'h3
    |=> stackPop && pcValue == $past(topOfStack) && ptr2 == $past(nsp))
    else $error("return step bad");
  chk_sp_math: assert property (arith && instrWord[7:6] == 2'h2
    |=> instrDone && ptr2 == $past(nsp)) else $error("pointer math bad");
  chk_abs_move: assert property (w2 && !mv_r[0] && instrWord[15:12] == 4'hF
    |=> memWr && instrDone && memAddr == $past(instrWord[11:0]))
    else $error("absolute move bad");
  chk_bad_word: assert property (w2 && instrWord[15:12] != 4'hF
    |=> instrDone && !memWr) else $error("bad second word wrote");
endmodule
bind eie_exec eie_exec_checker u_chk (.*);

// ---- sim/extended_instruction_execution_test.sv ----
`timescale 1ns/1ps
module extended_instruction_execution_test;
  logic mclk = 1'b0, rst_n = 1'b0, extSetEnable = 1'b1, instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000, rs = 16'h0FC6;
  logic [20:0] pcNow = 21'h000000, topOfStack = 21'h000000;
  logic [7:0] workingReg = 8'h00, pcHighLatch = 8'h00, pcUpperLatch = 8'h00;
  logic [7:0] memRdData = 8'h00, memWrData;
  logic [2:0] ptrLoad = 3'h0;
  logic [11:0] ptrLoadData = 12'h000, ptr0, ptr1, ptr2, memAddr;
  logic instrReady, instrDone, memRd, memWr, pcLoad, stackPush, stackPop;
  logic [20:0] pcValue, stackPushData;
  logic [11:0] m[3];
  int fails = 0, n_checks = 0;
  eie_exec dut (.*);
  always #10 mclk = ~mclk;
  function automatic logic [15:0] rnd();
    rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
    return rs;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Called at a falling edge; returns one cycle later with effects visible.
  // Valid stays up so back-to-back words never toggle it in one time step;
  // ldp drops it before any idle edge.
  task automatic issue(logic [15:0] w);
    instrValid = 1'b1;
    instrWord = w;
    @(negedge mclk);
  endtask
  task automatic ldp(logic [2:0] s, logic [11:0] v);
    instrValid = 1'b0;
    ptrLoad = s;
    ptrLoadData = v;
    @(negedge mclk);
    ptrLoad = 3'h0;
    for (int i = 0; i < 3; i++)
      if (s[i])
        m[i] = v;
  endtask
  task automatic mvt(logic [15:0] w1, w2, logic [7:0] d, logic [11:0] src,
                     logic rd, wr, logic [11:0] dst, logic [7:0] wd);
    issue(w1);
    chk("memRd", rd, memRd);
    if (rd)
      chk("src", src, memAddr);
    memRdData = d;
    issue(w2);
    chk("memWr", wr, memWr);
    chk("mvdone", 1, instrDone);
    if (wr) begin
      chk("dst", dst, memAddr);
      chk("data", wd, memWrData);
    end
  endtask
  initial begin
    #300000;
    fails++;
    stop_test();
  end
  initial begin
    logic [15:0] w;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    chk("ready", 1, instrReady);
    chk("rstptr", 0, ptr0);
    ldp(3'h7, 12'h3FF);
    for (int i = 0; i < 80; i++) begin
      w = rnd();
      extSetEnable = w[15] | w[14];
      w[15:9] = 7'h74;
      if (w[7:6] == 2'h3)
        w[7] = 1'b0;
      if (extSetEnable)
        m[w[7:6]] = w[8] ? m[w[7:6]] - w[5:0] : m[w[7:6]] + w[5:0];
      issue(w);
      chk("done", extSetEnable, instrDone);
      chk("ptr0", m[0], ptr0);
      chk("ptr1", m[1], ptr1);
      chk("ptr2", m[2], ptr2);
    end
    extSetEnable = 1'b1;
    w = rnd();
    issue({8'hEA, w[7:0]});
    chk("wraddr", m[2], memAddr);
    chk("wrdata", w[7:0], memWrData);
    m[2] = m[2] - 12'h001;
    chk("pushsp", m[2], ptr2);
    for (int s = 0; s < 2; s++) begin
      w = rnd();
      topOfStack = {5'h00, w};
      issue({7'h74, s[0], 2'h3, w[5:0]});
      m[2] = s ? m[2] - w[5:0] : m[2] + w[5:0];
      chk("pc", topOfStack, pcValue);
      chk("retsp", m[2], ptr2);
      @(negedge mclk);
      chk("retdone", 1, instrDone);
    end
    w = rnd();
    pcNow = {5'h1F, w};
    workingReg = w[7:0];
    pcHighLatch = w[15:8];
    pcUpperLatch = 8'hE5;
    issue(16'h0014);
    chk("retaddr", pcNow + 21'h000002, stackPushData);
    chk("target", {5'h05, w}, pcValue);
    chk("callsp", m[2], ptr2);
    @(negedge mclk);
    chk("calldone", 1, instrDone);
    // Move targets stay clear of PC low and top-of-stack bytes
    ldp(3'h4, 12'h100);
    mvt(16'hEB25, 16'hF3C4, 8'hA7, 12'h125, 1, 1, 12'h3C4, 8'hA7);
    ldp(3'h4, 12'hFE0);
    mvt(16'hEB0B, 16'hFFFF, 8'h5A, 12'hFEB, 0, 1, 12'hFFF, 8'h00);
    mvt(16'hEB80, 16'hF003, 8'h11, 12'hFE0, 1, 0, 12'h000, 8'h00);
    mvt(16'hEB81, 16'hF010, 8'h3C, 12'hFE1, 1, 1, 12'hFF0, 8'h3C);
    mvt(16'hEB01, 16'h0000, 8'h77, 12'hFE1, 1, 0, 12'h000, 8'h00);
    stop_test();
  end
endmodule
